/* logic/epm_pkg.sv */
// Purpose: shared constants and carriers for the receive pattern-match block
// Assumes: AXI4-Lite register bus, 32-bit data, one word per register
// Notes: offsets are byte addresses; fields sit in the low 16 bits, except the full 32-bit mask words and the status sum in bits 31:16
package epm_pkg;
	// register byte offsets
	localparam logic [7:0] OFS_MASK_LOW = 8'h00;
	localparam logic [7:0] OFS_MASK_HIGH = 8'h04;
	localparam logic [7:0] OFS_CHECKSUM = 8'h08;
	localparam logic [7:0] OFS_START = 8'h0C;
	localparam logic [7:0] OFS_FILTER = 8'h10;
	localparam logic [7:0] OFS_STATUS = 8'h14;
	// field positions
	localparam int MODE_LSB = 8;
	localparam int INVERT_BIT = 12;
	localparam int RECEIVE_ENABLE_BIT = 0;
	// reset values
	localparam logic [31:0] RST_MASK = 32'h0000_0000;
	localparam logic [15:0] RST_HALF = 16'h0000;
	localparam logic [3:0] RST_MODE = 4'h0;
	localparam logic [3:0] MODE_OFF = 4'h0;
	// AXI responses
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// received byte stream from the receive datapath
	typedef struct packed {
		logic valid;
		logic sof;
		logic eof;
		logic [7:0] data;
	} epm_byte_t;

	// per-frame qualifiers from other filters
	typedef struct packed {
		logic station;
		logic unicast;
		logic broadcast;
		logic hash;
		logic wake;
	} epm_qual_t;

	typedef enum logic [1:0] {
		EPM_RESP_OKAY,
		EPM_RESP_ERR
	} epm_resp_kind_t;
endpackage : epm_pkg

/* logic/epm_regmem.sv */
// Purpose: holds the pattern-match setting words
// Assumes: one write and one read port on aclk
// Notes: read data come out of a register
`timescale 1ns/10ps
module epm_regmem (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// write port
	input wire logic wr_en,
	input wire logic [1:0] wr_idx,
	input wire logic [31:0] wr_data,
	input wire logic [3:0] wr_strb,
	// read port
	input wire logic [1:0] rd_idx,
	output logic [31:0] rd_data,
	// live contents
	output logic [63:0] mask_bits,
	output logic [15:0] checksum,
	output logic [15:0] start_offset
);
	logic [31:0] word_reg [4];
	logic [31:0] word_next [4];
	logic [31:0] rd_reg;
	logic [31:0] rd_next;

	// byte-lane update; upper halves of the two short words stay zero
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			word_next[i] = word_reg[i];
			if (wr_en && wr_idx == 2'(i)) begin
				for (int b = 0; b < 4; b++) begin
					if (wr_strb[b]) begin
						word_next[i][b*8 +: 8] = wr_data[b*8 +: 8];
					end
				end
			end
		end
		word_next[2][31:16] = 16'h0000;
		word_next[3][31:16] = 16'h0000;
		rd_next = word_reg[rd_idx];
	end

	// storage, cleared at reset
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			for (int i = 0; i < 4; i++) begin
				word_reg[i] <= epm_pkg::RST_MASK;
			end
			rd_reg <= epm_pkg::RST_MASK;
		end else begin
			for (int i = 0; i < 4; i++) begin
				word_reg[i] <= word_next[i];
			end
			rd_reg <= rd_next;
		end
	end

	assign rd_data = rd_reg;
	assign mask_bits = {word_reg[1], word_reg[0]};
	assign checksum = word_reg[2][15:0];
	assign start_offset = word_reg[3][15:0];
endmodule : epm_regmem

/* logic/epm_top.sv */
// Purpose: receive pattern-match settings with AXI4-Lite access and matcher
// Assumes: received bytes and qualifiers arrive on aclk
// Notes: transmit path has no connection to this block
`timescale 1ns/10ps

module epm_top (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite write address
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// AXI4-Lite write data
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read address
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	// AXI4-Lite read data
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// receive datapath
	input wire epm_pkg::epm_byte_t rx_byte,
	input wire epm_pkg::epm_qual_t rx_qual,
	// match result
	output logic match_done,
	output logic match_ok,
	output logic receive_enable
);
	// write channel state
	logic aw_held_reg, aw_held_next;
	logic w_held_reg, w_held_next;
	logic [7:0] aw_addr_reg, aw_addr_next;
	logic [31:0] w_data_reg, w_data_next;
	logic [3:0] w_strb_reg, w_strb_next;
	logic bvalid_reg, bvalid_next;
	logic [1:0] bresp_reg, bresp_next;
	logic awready_reg, awready_next;
	logic wready_reg, wready_next;
	// read channel state
	logic rpend_reg, rpend_next;
	logic rvalid_reg, rvalid_next;
	logic [1:0] rresp_reg, rresp_next;
	logic [31:0] rdata_reg, rdata_next;
	logic [7:0] ar_addr_reg, ar_addr_next;
	logic arready_reg, arready_next;
	// filter config and control
	logic [3:0] mode_reg, mode_next;
	logic invert_reg, invert_next;
	logic receive_enable_reg, receive_enable_next;
	// matcher state
	logic [15:0] pos_reg, pos_next;
	logic [15:0] sum_reg, sum_next;
	logic done_reg, done_next;
	logic ok_reg, ok_next;
	logic [15:0] last_sum_reg, last_sum_next;
	logic [1:0] mem_rd_idx;
	// memory ports
	logic mem_wr;
	logic [31:0] mem_rdata;
	logic [63:0] mask_bits;
	logic [15:0] checksum;
	logic [15:0] start_offset;
	logic do_write;

	// address classification used by both channels
	function automatic logic in_mem(input logic [7:0] a);
		in_mem = (a[7:4] == 4'h0) && (a[1:0] == 2'h0);
	endfunction : in_mem

	function automatic logic known(input logic [7:0] a);
		known = in_mem(a) || a == epm_pkg::OFS_FILTER || a == epm_pkg::OFS_STATUS;
	endfunction : known

	assign do_write = aw_held_reg && w_held_reg && !bvalid_reg;
	assign mem_wr = do_write && in_mem(aw_addr_reg);

	epm_regmem epm_regmem_inst (
		.aclk(aclk),
		.aresetn(aresetn),
		.wr_en(mem_wr),
		.wr_idx(aw_addr_reg[3:2]),
		.wr_data(w_data_reg),
		.wr_strb(w_strb_reg),
		.rd_idx(mem_rd_idx), // word fetched on the take edge, so data are fresh
		.rd_data(mem_rdata),
		.mask_bits(mask_bits),
		.checksum(checksum),
		.start_offset(start_offset)
	);

	// write path: take address and data in either order, then answer
	always_comb begin
		aw_held_next = aw_held_reg;
		w_held_next = w_held_reg;
		aw_addr_next = aw_addr_reg;
		w_data_next = w_data_reg;
		w_strb_next = w_strb_reg;
		bvalid_next = bvalid_reg;
		bresp_next = bresp_reg;
		mode_next = mode_reg;
		invert_next = invert_reg;
		receive_enable_next = receive_enable_reg;
		if (s_axi_awvalid && !aw_held_reg) begin
			aw_held_next = 1'b1;
			aw_addr_next = s_axi_awaddr;
		end
		if (s_axi_wvalid && !w_held_reg) begin
			w_held_next = 1'b1;
			w_data_next = s_axi_wdata;
			w_strb_next = s_axi_wstrb;
		end
		if (do_write) begin
			aw_held_next = 1'b0;
			w_held_next = 1'b0;
			bvalid_next = 1'b1;
			bresp_next = known(aw_addr_reg) ? epm_pkg::RESP_OKAY : epm_pkg::RESP_SLVERR;
			if (aw_addr_reg == epm_pkg::OFS_FILTER && w_strb_reg[1]) begin
				mode_next = w_data_reg[epm_pkg::MODE_LSB +: 4];
				invert_next = w_data_reg[epm_pkg::INVERT_BIT];
			end
			if (aw_addr_reg == epm_pkg::OFS_STATUS && w_strb_reg[0]) begin
				receive_enable_next = w_data_reg[epm_pkg::RECEIVE_ENABLE_BIT];
			end
		end
		if (bvalid_reg && s_axi_bready) begin
			bvalid_next = 1'b0;
		end
		awready_next = !aw_held_next;
		wready_next = !w_held_next;
	end

	// read path: one cycle to fetch from memory, then present data
	always_comb begin
		rpend_next = rpend_reg;
		rvalid_next = rvalid_reg;
		rresp_next = rresp_reg;
		rdata_next = rdata_reg;
		ar_addr_next = ar_addr_reg;
		mem_rd_idx = ar_addr_reg[3:2];
		if (s_axi_arvalid && !rpend_reg && !rvalid_reg) begin
			rpend_next = 1'b1;
			ar_addr_next = s_axi_araddr;
			mem_rd_idx = s_axi_araddr[3:2];
		end
		if (rpend_reg) begin
			rpend_next = 1'b0;
			rvalid_next = 1'b1;
			rresp_next = known(ar_addr_reg) ? epm_pkg::RESP_OKAY : epm_pkg::RESP_SLVERR;
			rdata_next = 32'h0000_0000;
			if (in_mem(ar_addr_reg)) begin
				rdata_next = mem_rdata;
			end else if (ar_addr_reg == epm_pkg::OFS_FILTER) begin
				rdata_next[epm_pkg::MODE_LSB +: 4] = mode_reg;
				rdata_next[epm_pkg::INVERT_BIT] = invert_reg;
			end else if (ar_addr_reg == epm_pkg::OFS_STATUS) begin
				rdata_next[epm_pkg::RECEIVE_ENABLE_BIT] = receive_enable_reg;
				rdata_next[31:16] = last_sum_reg;
				rdata_next[1] = ok_reg;
			end
		end
		if (rvalid_reg && s_axi_rready) begin
			rvalid_next = 1'b0;
		end
		arready_next = !rpend_next && !rvalid_next;
	end

	// matcher: masked byte sum from the start offset, one frame at a time
	always_comb begin
		logic [15:0] idx;
		logic hit;
		logic qual_ok;
		idx = pos_reg - start_offset;
		hit = 1'b0;
		qual_ok = 1'b0;
		pos_next = pos_reg;
		sum_next = sum_reg;
		done_next = 1'b0;
		ok_next = ok_reg;
		last_sum_next = last_sum_reg;
		if (receive_enable_reg && rx_byte.valid) begin
			if (rx_byte.sof) begin
				pos_next = 16'h0001;
				sum_next = 16'h0000;
				idx = 16'h0000 - start_offset;
			end else begin
				pos_next = pos_reg + 16'h0001;
			end
			hit = ((rx_byte.sof ? 16'h0000 : pos_reg) >= start_offset)
				&& (idx < 16'h0040) && mask_bits[idx[5:0]];
			if (hit) begin
				sum_next = (rx_byte.sof ? 16'h0000 : sum_reg) + {8'h00, rx_byte.data};
			end
			if (rx_byte.eof) begin
				done_next = 1'b1;
				last_sum_next = sum_next;
				case (mode_reg)
					4'h1: qual_ok = 1'b1;
					4'h2, 4'h3: qual_ok = rx_qual.station;
					4'h4, 4'h5: qual_ok = rx_qual.unicast;
					4'h6, 4'h7: qual_ok = rx_qual.broadcast;
					4'h8: qual_ok = rx_qual.hash;
					4'h9: qual_ok = rx_qual.wake;
					default: qual_ok = 1'b0;
				endcase
				ok_next = (mode_reg != epm_pkg::MODE_OFF) && qual_ok
					&& (invert_reg ^ (sum_next == checksum));
			end
		end
	end

	// register all state
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_reg <= 1'b0;
			w_held_reg <= 1'b0;
			aw_addr_reg <= 8'h00;
			w_data_reg <= 32'h0000_0000;
			w_strb_reg <= 4'h0;
			bvalid_reg <= 1'b0;
			bresp_reg <= epm_pkg::RESP_OKAY;
			rpend_reg <= 1'b0;
			rvalid_reg <= 1'b0;
			rresp_reg <= epm_pkg::RESP_OKAY;
			rdata_reg <= 32'h0000_0000;
			ar_addr_reg <= 8'h00;
			awready_reg <= 1'b1;
			wready_reg <= 1'b1;
			arready_reg <= 1'b1;
			mode_reg <= epm_pkg::RST_MODE;
			invert_reg <= 1'b0;
			receive_enable_reg <= 1'b0;
			pos_reg <= epm_pkg::RST_HALF;
			sum_reg <= epm_pkg::RST_HALF;
			done_reg <= 1'b0;
			ok_reg <= 1'b0;
			last_sum_reg <= epm_pkg::RST_HALF;
		end else begin
			aw_held_reg <= aw_held_next;
			w_held_reg <= w_held_next;
			aw_addr_reg <= aw_addr_next;
			w_data_reg <= w_data_next;
			w_strb_reg <= w_strb_next;
			bvalid_reg <= bvalid_next;
			bresp_reg <= bresp_next;
			rpend_reg <= rpend_next;
			rvalid_reg <= rvalid_next;
			rresp_reg <= rresp_next;
			rdata_reg <= rdata_next;
			ar_addr_reg <= ar_addr_next;
			awready_reg <= awready_next;
			wready_reg <= wready_next;
			arready_reg <= arready_next;
			mode_reg <= mode_next;
			invert_reg <= invert_next;
			receive_enable_reg <= receive_enable_next;
			pos_reg <= pos_next;
			sum_reg <= sum_next;
			done_reg <= done_next;
			ok_reg <= ok_next;
			last_sum_reg <= last_sum_next;
		end
	end

	// outputs straight from flip-flops
	assign s_axi_awready = awready_reg;
	assign s_axi_wready = wready_reg;
	assign s_axi_bvalid = bvalid_reg;
	assign s_axi_bresp = bresp_reg;
	assign s_axi_arready = arready_reg;
	assign s_axi_rvalid = rvalid_reg;
	assign s_axi_rresp = rresp_reg;
	assign s_axi_rdata = rdata_reg;
	assign match_done = done_reg;
	assign match_ok = ok_reg;
	assign receive_enable = receive_enable_reg;
endmodule : epm_top

/* bench/epm_top_properties.sv */
// Purpose: timing and field checks on the pattern-match block ports
// Assumes: one clock, synchronous active-low reset
// Notes: bound to every epm_top instance
`timescale 1ns/10ps
module epm_chk (
	// clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// register bus
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// receive side
	input wire epm_pkg::epm_byte_t rx_byte,
	input wire logic match_done,
	input wire logic match_ok,
	input wire logic receive_enable
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	logic [7:0] ra_reg;
	// address of the read in flight
	always_ff @(posedge aclk) begin
		if (!aresetn) ra_reg <= 8'h00;
		else if (s_axi_arvalid && s_axi_arready) ra_reg <= s_axi_araddr;
	end
	sequence rd_take; s_axi_arvalid && s_axi_arready; endsequence
	sequence wr_take; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready; endsequence
	sequence rx_last; rx_byte.valid && rx_byte.eof && receive_enable; endsequence
	rd_latency_a: assert property (rd_take |=> !s_axi_rvalid ##1 s_axi_rvalid)
		else $error("read answer not on time");
	wr_latency_a: assert property (wr_take |-> ##[1:2] s_axi_bvalid)
		else $error("write answer not on time");
	rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
		s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
		s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write answer dropped");
	upper_zero_a: assert property (s_axi_rvalid && (ra_reg == epm_pkg::OFS_CHECKSUM ||
		ra_reg == epm_pkg::OFS_START) |-> s_axi_rdata[31:16] == 16'h0000)
		else $error("upper half not zero");
	unmapped_read_a: assert property (s_axi_rvalid && ra_reg > epm_pkg::OFS_STATUS |->
		s_axi_rresp == epm_pkg::RESP_SLVERR && s_axi_rdata == 32'h0)
		else $error("unmapped read answered");
	done_after_a: assert property (rx_last |=> match_done)
		else $error("no result after last byte");
	ok_change_a: assert property ($changed(match_ok) |-> match_done)
		else $error("result moved between frames");
endmodule : epm_chk
bind epm_top epm_chk epm_chk_inst (.*);

/* bench/eth_rx_pattern_match_regs_tb_top.sv */
// Purpose: self-checking bench for the pattern-match settings block
// Assumes: bus tasks note expected answers, monitors compare them
// Notes: random data from a bench shift register with a fixed start
`timescale 1ns/10ps
module eth_rx_pattern_match_regs_tb_top;
	logic aclk = 1'b0, aresetn = 1'b0;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic [3:0] s_axi_wstrb = 4'h0;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	epm_pkg::epm_byte_t rx_byte = '0;
	epm_pkg::epm_qual_t rx_qual = '0;
	logic match_done, match_ok, receive_enable;
	logic [33:0] rq [$];
	logic [1:0] bq [$];
	logic mq [$];
	logic [63:0] msk;
	logic [31:0] rnd = 32'hD28F49BB;
	int mismatches = 0, checks = 0;
	epm_top epm_top_inst (.*);
	// 200 MHz clock
	always #2.5 aclk = ~aclk;
	function automatic logic [31:0] lfsr(input logic [31:0] v);
		return {v[30:0], 1'b0} ^ (v[31] ? 32'h04C11DB7 : 32'h0);
	endfunction : lfsr
	task automatic chk(input string n, input logic [33:0] s, input logic [33:0] e);
		checks++;
		if (s !== e) begin
			mismatches++;
			$display("BAD %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
		bq.push_back(a > epm_pkg::OFS_STATUS ? epm_pkg::RESP_SLVERR : epm_pkg::RESP_OKAY);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		s_axi_bready <= 1'b0;
		@(posedge aclk);
	endtask : wr
	task automatic rd(input logic [7:0] a, input logic [31:0] d);
		rq.push_back({a > epm_pkg::OFS_STATUS ? epm_pkg::RESP_SLVERR : epm_pkg::RESP_OKAY, d});
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		s_axi_rready <= 1'b0;
		@(posedge aclk);
	endtask : rd
	// one frame under a given mode and inversion
	task automatic run_case(input logic [3:0] m, input logic inv, input logic hit);
		logic [7:0] b [70];
		logic [15:0] s;
		logic q;
		s = 16'h0;
		wr(epm_pkg::OFS_STATUS, 32'h0, 4'hF);
		rnd = lfsr(rnd);
		msk[31:0] = rnd;
		rnd = lfsr(rnd);
		msk[63:32] = rnd;
		wr(epm_pkg::OFS_MASK_LOW, msk[31:0], 4'hF);
		wr(epm_pkg::OFS_MASK_HIGH, msk[63:32], 4'hF);
		rd(epm_pkg::OFS_MASK_HIGH, msk[63:32]);
		for (int p = 0; p < 70; p++) begin
			rnd = lfsr(rnd);
			b[p] = rnd[7:0];
			if (p >= 3 && p < 67 && msk[p - 3]) s = s + 16'(b[p]);
		end
		if (!hit) s = s ^ 16'h0100;
		wr(epm_pkg::OFS_CHECKSUM, {rnd[31:16], s}, 4'hF);
		wr(epm_pkg::OFS_FILTER, {19'h0, inv, m, 8'h00}, 4'hF);
		rd(epm_pkg::OFS_FILTER, {19'h0, inv, m, 8'h00});
		wr(epm_pkg::OFS_STATUS, 32'h1, 4'hF);
		chk("receive_enable", 34'(receive_enable), 34'h1);
		rx_qual <= epm_pkg::epm_qual_t'(rnd[12:8]);
		case (m)
			4'h1: q = 1'b1;
			4'h2, 4'h3: q = rnd[12];
			4'h4, 4'h5: q = rnd[11];
			4'h6, 4'h7: q = rnd[10];
			4'h8: q = rnd[9];
			4'h9: q = rnd[8];
			default: q = 1'b0;
		endcase
		mq.push_back(q && (hit ^ inv));
		for (int p = 0; p < 70; p++) begin
			rx_byte <= '{1'b1, p == 0, p == 69, b[p]};
			@(posedge aclk);
		end
		rx_byte <= '0;
		wr(epm_pkg::OFS_STATUS, 32'h0, 4'hF);
	endtask : run_case
	task automatic test_done();
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : test_done
	// compare each answer with the oldest note
	always @(posedge aclk) begin
		if (s_axi_bvalid && s_axi_bready) begin
			chk("bresp", 34'(s_axi_bresp), 34'(bq.pop_front()));
		end
		if (s_axi_rvalid && s_axi_rready) begin
			chk("read", {s_axi_rresp, s_axi_rdata}, rq.pop_front());
		end
		if (match_done) begin
			chk("match", 34'(match_ok), mq.size() != 0 ? 34'(mq.pop_front()) : 34'hX);
		end
	end
	// main sequence
	initial begin
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		for (int i = 0; i < 4; i++) rd(8'(4 * i), 32'h0);
		wr(epm_pkg::OFS_CHECKSUM, 32'hFFFFFFFF, 4'hF);
		rd(epm_pkg::OFS_CHECKSUM, 32'h0000FFFF);
		wr(epm_pkg::OFS_START, 32'hA5A50003, 4'hF);
		rd(epm_pkg::OFS_START, 32'h00000003);
		wr(epm_pkg::OFS_MASK_LOW, 32'h12345678, 4'hF);
		wr(epm_pkg::OFS_MASK_LOW, 32'hAAAAAAAA, 4'h2);
		rd(epm_pkg::OFS_MASK_LOW, 32'h1234AA78);
		wr(8'h20, 32'h5A5A5A5A, 4'hF);
		rd(8'h20, 32'h0);
		for (int m = 0; m < 16; m++) begin
			for (int k = 0; k < 2; k++) run_case(4'(m), k[0], rnd[7]);
		end
		// a reset in mid-run clears every setting again
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		for (int i = 0; i < 4; i++) rd(8'(4 * i), 32'h0);
		// a frame while receive is off must give no result
		rx_byte <= '{1'b1, 1'b1, 1'b1, 8'h55};
		@(posedge aclk);
		rx_byte <= '0;
		repeat (4) @(posedge aclk);
		chk("left", 34'(rq.size() + bq.size() + mq.size()), 34'h0);
		test_done();
	end
	// cut a hang short
	initial begin
		#100000;
		mismatches++;
		test_done();
	end
endmodule : eth_rx_pattern_match_regs_tb_top
